// ==== core/adc_cfg_pkg.sv ====
/*
 Constants, register map and command codes shared by both link ends.
 Assumes one 100 MHz clock per end; the master clock equals that clock.
*/
// What this block does
// - Fixed identity nibble high, low bits zero
// - Control bit 7 picks pulse or continuous sync
// - Control bit 6 picks low power or resolution
// - Rate field bits 5:3 sets 250 to 4000 SPS
// - Control bit 2 picks linear or minimum phase
// - Bits 1:0 pick bypass, sinc, lowpass, highpass
// - Bits 6:4 pick input pair or short
// - Bit 3 enables amplifier chopping, default on
// - Gain field is power of two up to 64
// - Highpass corner low byte 03h, high 04h
// - Offset word bytes 05h low to 07h high
// - Full-scale word 08h..0Ah, high resets 40h
// - Reset pin, or 64 idle periods in continuous mode, recover port
// - Host stops continuous read before register access
// - Sync low halts, rising edge realigns conversions
// - Continuous mode shifts result after ready falls
// - Without continuous mode, ready follows read command
// - Register write restarts converter, 63 readings lost
// - Two-byte opcode: address with base, count minus one
// - Host waits 24 master clocks between bytes
package adc_cfg_pkg;
    localparam int NUM_REGS = 11;
    localparam logic [4:0] ADDR_IDENTITY = 5'h00;
    localparam logic [4:0] ADDR_INPUT_GAIN = 5'h02;
    localparam logic [7:0] RST_CONV_CTRL = 8'h52;
    localparam logic [7:0] RST_INPUT_GAIN = 8'h08;
    localparam logic [7:0] RST_HP_LOW = 8'h32;
    localparam logic [7:0] RST_HP_HIGH = 8'h03;
    localparam logic [7:0] RST_CORR_ZERO = 8'h00;
    localparam logic [7:0] RST_FS_HIGH = 8'h40;
    // Reserved input-gain bit 7 never stores a one
    localparam logic [7:0] INPUT_GAIN_WMASK = 8'h7F;
    // Field positions
    localparam int CC_SYNC_BIT = 7;
    localparam int CC_POWER_BIT = 6;
    localparam int CC_RATE_LSB = 3;
    localparam int CC_PHASE_BIT = 2;
    localparam int CC_FILTER_LSB = 0;
    localparam int IG_INSEL_LSB = 4;
    localparam int IG_AMP_CHOPPING_ENABLE_BIT = 3;
    localparam int IG_GAIN_LSB = 0;
    localparam int ID_NIBBLE_LSB = 4;
    localparam logic [2:0] RATE_FASTEST = 3'h4;
    // Command bytes
    localparam logic [7:0] OP_CONT_READ = 8'h10;
    localparam logic [7:0] OP_STOP_CONT = 8'h11;
    localparam logic [7:0] OP_READ_DATA = 8'h12;
    localparam logic [7:0] OP_REG_READ = 8'h20;
    localparam logic [7:0] OP_REG_WRITE = 8'h40;
    localparam logic [7:0] OP_CLASS_MASK = 8'hE0;
    // Timing
    localparam int CLK_HZ = 100_000_000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int FASTEST_SPS = 4000;
    localparam int FASTEST_PERIOD_CLKS = CLK_HZ / FASTEST_SPS;
    localparam int SETTLE_READINGS = 63;
    localparam int RECOVERY_PERIODS = 64;
    localparam int BYTE_GAP_CLKS = 24;
    localparam int SCLK_PERIOD_NS = 160;
    localparam int SCLK_HALF_CLKS = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int RESET_PULSE_CLKS = 4;
    // Host request codes
    typedef enum logic [2:0] {
        HOP_STOP_CONT = 3'h0,
        HOP_CONT_READ = 3'h1,
        HOP_READ_DATA = 3'h2,
        HOP_REG_READ = 3'h3,
        HOP_REG_WRITE = 3'h4,
        HOP_CONT_FETCH = 3'h5
    } host_op_t;
endpackage : adc_cfg_pkg

// ==== core/adc_link_if.sv ====
/*
 Serial link between converter end and host end.
 Assumes both ends run their own clk; all lines are one-way.
*/
`timescale 1ns/1ps
`default_nettype none
interface adc_link_if;
    logic sclk;
    logic din;
    logic dout;
    logic result_ready_n;
    logic sync;
    logic reset_pin_n;
    modport device (input sclk, input din, input sync, input reset_pin_n,
        output dout, output result_ready_n);
    modport host (output sclk, output din, output sync, output reset_pin_n,
        input dout, input result_ready_n);
endinterface : adc_link_if
`default_nettype wire

// ==== core/adc_cfg_device.sv ====
/*
 Converter end: serial command port, register bank and conversion pacing.
 Assumes link pins are asynchronous to clk and the sample value comes
 from logic on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_cfg_device #(
    parameter int PERIOD_CLKS = adc_cfg_pkg::FASTEST_PERIOD_CLKS,
    parameter logic [3:0] IDENTITY = 4'hA // Arbitrary value
) (
    input wire logic clk,
    input wire logic resetn,
    adc_link_if.device link,
    input wire logic [23:0] sample_in,
    output logic sync_mode,
    output logic power_high,
    output logic [2:0] rate_select,
    output logic phase_min,
    output logic [1:0] filter_chain_select,
    output logic [2:0] input_selector,
    output logic amp_chopping_enable,
    output logic [2:0] gain_amplifier,
    output logic [15:0] highpass_corner,
    output logic [23:0] offset_correction,
    output logic [23:0] fullscale_correction,
    output logic continuous
);
    import adc_cfg_pkg::*;

    // ==========================================================
    // Checks and state
    initial begin
        if (PERIOD_CLKS < 2 || PERIOD_CLKS > 65535) begin
            $error("PERIOD_CLKS out of range");
        end
    end

    typedef enum logic [3:0] {
        PH_CMD = 4'b0001,
        PH_COUNT = 4'b0010,
        PH_WDATA = 4'b0100,
        PH_RDATA = 4'b1000
    } dev_phase_t;

    typedef struct packed {
        logic [2:0] sclk_p;
        logic [1:0] din_p;
        logic [2:0] sync_p;
        logic [1:0] rpin_p;
        dev_phase_t phase;
        logic [7:0] rx;
        logic [2:0] bitn;
        logic [23:0] tx;
        logic fresh;
        logic dout;
        logic rr_n;
        logic rr_pend;
        logic cont;
        logic is_write;
        logic [4:0] addr;
        logic [4:0] left;
        logic [NUM_REGS-1:0][7:0] regs;
        logic [19:0] rate_cnt;
        logic [5:0] settle;
        logic [23:0] result;
        logic [6:0] idle_cnt;
    } dev_state_t;

    localparam logic [NUM_REGS-1:0][7:0] REG_RESET = {RST_FS_HIGH, RST_CORR_ZERO,
        RST_CORR_ZERO, RST_CORR_ZERO, RST_CORR_ZERO, RST_CORR_ZERO, RST_HP_HIGH,
        RST_HP_LOW, RST_INPUT_GAIN, RST_CONV_CTRL, {IDENTITY, 4'h0}};

    dev_state_t s;
    dev_state_t next_s;
    logic [19:0] period;
    logic [7:0] byte_in;
    logic [4:0] next_addr;
    logic sclk_rise;
    logic sclk_fall;
    logic sync_rise;
    logic conv_done;

    // Register bank read port; unmapped addresses read as zero
    function automatic logic [7:0] reg_rd(input dev_state_t st, input logic [4:0] a);
        reg_rd = (a < 5'(NUM_REGS)) ? st.regs[a] : 8'h00;
    endfunction : reg_rd

    // ==========================================================
    // Next-state logic
    always_comb begin
        next_s = s;
        // Two flops on every pin before any logic looks at it
        next_s.sclk_p = {s.sclk_p[1:0], link.sclk};
        next_s.din_p = {s.din_p[0], link.din};
        next_s.sync_p = {s.sync_p[1:0], link.sync};
        next_s.rpin_p = {s.rpin_p[0], link.reset_pin_n};
        sclk_rise = s.sclk_p[1] & ~s.sclk_p[2];
        sclk_fall = ~s.sclk_p[1] & s.sclk_p[2];
        sync_rise = s.sync_p[1] & ~s.sync_p[2];
        byte_in = {s.rx[6:0], s.din_p[1]};
        next_addr = s.addr + 5'h01;
        // Reserved rate codes run at the fastest rate
        if (s.regs[1][CC_RATE_LSB+:3] > RATE_FASTEST) begin
            period = 20'(PERIOD_CLKS);
        end else begin
            period = 20'(PERIOD_CLKS) << (RATE_FASTEST - s.regs[1][CC_RATE_LSB+:3]);
        end
        conv_done = s.sync_p[1] && (s.rate_cnt == period - 20'h1);

        // Conversion pacing: sync low halts, rising edge realigns
        if (!s.sync_p[1]) begin
            next_s.rate_cnt = '0;
        end else if (sync_rise) begin
            next_s.rate_cnt = '0;
            // Pulse mode discards settling readings; continuous mode keeps flowing
            if (!s.regs[1][CC_SYNC_BIT]) begin
                next_s.settle = 6'(SETTLE_READINGS);
            end
        end else if (conv_done) begin
            next_s.rate_cnt = '0;
            next_s.result = sample_in;
            if (s.settle != '0) begin
                next_s.settle = s.settle - 6'h01;
            end else if (s.cont) begin
                // Raise then drop ready so every new result shows a falling edge
                next_s.rr_n = 1'b1;
                next_s.rr_pend = 1'b1;
            end
        end else begin
            next_s.rate_cnt = s.rate_cnt + 20'h1;
        end

        // Port recovery: clock held low for a run of periods in continuous mode
        if (!s.cont || s.sclk_p[1]) begin
            next_s.idle_cnt = '0;
        end else if (conv_done) begin
            if (s.idle_cnt == 7'(RECOVERY_PERIODS - 1)) begin
                next_s.idle_cnt = '0;
                next_s.phase = PH_CMD;
                next_s.bitn = '0;
            end else begin
                next_s.idle_cnt = s.idle_cnt + 7'h01;
            end
        end

        // Result handed to the shifter one cycle after ready went high
        if (s.rr_pend) begin
            next_s.rr_pend = 1'b0;
            next_s.rr_n = 1'b0;
            next_s.tx = s.result;
            next_s.dout = s.result[23];
            next_s.fresh = s.sclk_p[1];
        end

        // Output shifter moves on the falling clock edge
        if (sclk_fall) begin
            if (s.fresh) begin
                next_s.fresh = 1'b0;
            end else begin
                next_s.tx = {s.tx[22:0], 1'b0};
                next_s.dout = s.tx[22];
            end
        end

        // Input byte assembly on the rising clock edge
        if (sclk_rise) begin
            next_s.rx = byte_in;
            next_s.bitn = s.bitn + 3'h1;
            next_s.rr_n = 1'b1;
            if (s.bitn == 3'h7) begin
                unique case (s.phase)
                    PH_CMD: begin
                        if (byte_in == OP_STOP_CONT) begin
                            next_s.cont = 1'b0;
                        end else if (byte_in == OP_CONT_READ) begin
                            next_s.cont = 1'b1;
                        end else if (!s.cont) begin
                            // Register and data commands only outside continuous mode
                            if (byte_in == OP_READ_DATA) begin
                                next_s.rr_pend = 1'b1;
                            end else if ((byte_in & OP_CLASS_MASK) == OP_REG_READ ||
                                    (byte_in & OP_CLASS_MASK) == OP_REG_WRITE) begin
                                next_s.addr = byte_in[4:0];
                                next_s.is_write = (byte_in & OP_CLASS_MASK) == OP_REG_WRITE;
                                next_s.phase = PH_COUNT;
                            end
                        end
                    end
                    PH_COUNT: begin
                        next_s.left = byte_in[4:0];
                        if (s.is_write) begin
                            next_s.phase = PH_WDATA;
                        end else begin
                            next_s.phase = PH_RDATA;
                            next_s.tx = {reg_rd(s, s.addr), 16'h0000};
                            next_s.dout = next_s.tx[23];
                            next_s.fresh = 1'b1;
                        end
                    end
                    PH_WDATA: begin
                        // Identity is read-only; its low bits stay zero
                        if (s.addr != ADDR_IDENTITY && s.addr < 5'(NUM_REGS)) begin
                            if (s.addr == ADDR_INPUT_GAIN) begin
                                next_s.regs[s.addr] = byte_in & INPUT_GAIN_WMASK;
                            end else begin
                                next_s.regs[s.addr] = byte_in;
                            end
                        end
                        next_s.addr = next_addr;
                        next_s.left = s.left - 5'h01;
                        if (s.left == '0) begin
                            next_s.phase = PH_CMD;
                            next_s.settle = 6'(SETTLE_READINGS);
                            next_s.rate_cnt = '0;
                        end
                    end
                    PH_RDATA: begin
                        next_s.addr = next_addr;
                        next_s.left = s.left - 5'h01;
                        next_s.tx = {reg_rd(s, next_addr), 16'h0000};
                        next_s.dout = next_s.tx[23];
                        next_s.fresh = 1'b1;
                        if (s.left == '0) begin
                            next_s.phase = PH_CMD;
                        end
                    end
                endcase
            end
        end

        // Reset pin restores defaults and continuous mode
        if (!s.rpin_p[1]) begin
            next_s.regs = REG_RESET;
            next_s.cont = 1'b1;
            next_s.phase = PH_CMD;
            next_s.bitn = '0;
            next_s.rr_n = 1'b1;
            next_s.rr_pend = 1'b0;
            next_s.rate_cnt = '0;
            next_s.settle = 6'(SETTLE_READINGS);
            next_s.idle_cnt = '0;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s <= '{phase: PH_CMD, rr_n: 1'b1, cont: 1'b1, regs: REG_RESET,
                settle: 6'(SETTLE_READINGS), rpin_p: 2'b11, default: '0};
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Outputs: link pins and continuous from state, the rest straight from the register bank
    assign link.dout = s.dout;
    assign link.result_ready_n = s.rr_n;
    assign sync_mode = s.regs[1][CC_SYNC_BIT];
    assign power_high = s.regs[1][CC_POWER_BIT];
    assign rate_select = s.regs[1][CC_RATE_LSB+:3];
    assign phase_min = s.regs[1][CC_PHASE_BIT];
    assign filter_chain_select = s.regs[1][CC_FILTER_LSB+:2];
    // Reserved codes pass through unchanged; downstream treats them as defined
    assign input_selector = s.regs[2][IG_INSEL_LSB+:3];
    assign amp_chopping_enable = s.regs[2][IG_AMP_CHOPPING_ENABLE_BIT];
    assign gain_amplifier = s.regs[2][IG_GAIN_LSB+:3];
    assign highpass_corner = {s.regs[4], s.regs[3]};
    assign offset_correction = {s.regs[7], s.regs[6], s.regs[5]};
    assign fullscale_correction = {s.regs[10], s.regs[9], s.regs[8]};
    assign continuous = s.cont;
endmodule : adc_cfg_device
`default_nettype wire

// ==== core/adc_cfg_host.sv ====
/*
 Host end: sequences command bytes, pin reset and sync for the converter.
 Assumes the converter's master clock equals clk, and requests come from
 logic on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_cfg_host (
    input wire logic clk,
    input wire logic resetn,
    adc_link_if.host link,
    input wire logic req_valid,
    input wire adc_cfg_pkg::host_op_t req_op,
    input wire logic [4:0] req_addr,
    input wire logic [7:0] req_wdata,
    output logic req_ready,
    output logic resp_valid,
    output logic [23:0] resp_data,
    input wire logic sync_level,
    input wire logic reset_req
);
    import adc_cfg_pkg::*;

    // ==========================================================
    // State
    typedef enum logic [3:0] {
        HS_IDLE = 4'b0001,
        HS_GAP = 4'b0010,
        HS_WAIT = 4'b0100,
        HS_SHIFT = 4'b1000
    } host_state_t;

    typedef struct packed {
        host_state_t st;
        logic [3:0] div;
        logic [2:0] bitn;
        logic sclk;
        logic din;
        logic [7:0] txb;
        logic [2:0] idx;
        logic [2:0] nbytes;
        logic [2:0] wait_at;
        logic [3:0][7:0] seq;
        logic [23:0] rx;
        logic [4:0] gap;
        logic [1:0] rr_p;
        logic [1:0] dout_p;
        logic [2:0] rpulse;
        logic sync_o;
        logic ready;
        logic rvalid;
    } host_st_t;

    host_st_t s;
    host_st_t next_s;

    // ==========================================================
    // Next-state logic
    always_comb begin
        next_s = s;
        next_s.rr_p = {s.rr_p[0], link.result_ready_n};
        next_s.dout_p = {s.dout_p[0], link.dout};
        next_s.rvalid = 1'b0;
        next_s.sync_o = sync_level;
        // Reset pin pulse of fixed length
        if (reset_req) begin
            next_s.rpulse = 3'(RESET_PULSE_CLKS);
        end else if (s.rpulse != '0) begin
            next_s.rpulse = s.rpulse - 3'h1;
        end

        unique case (s.st)
            HS_IDLE: begin
                if (req_valid) begin
                    next_s.ready = 1'b0;
                    next_s.idx = '0;
                    next_s.gap = '0;
                    next_s.st = HS_GAP;
                    next_s.wait_at = 3'h7;
                    next_s.seq = '0;
                    next_s.nbytes = 3'h1;
                    case (req_op)
                        HOP_STOP_CONT: next_s.seq[0] = OP_STOP_CONT;
                        HOP_CONT_READ: next_s.seq[0] = OP_CONT_READ;
                        HOP_READ_DATA: begin
                            next_s.seq[0] = OP_READ_DATA;
                            next_s.wait_at = 3'h1;
                            next_s.nbytes = 3'h4;
                        end
                        HOP_REG_READ: begin
                            next_s.seq[0] = OP_REG_READ | {3'h0, req_addr};
                            next_s.nbytes = 3'h3;
                        end
                        HOP_REG_WRITE: begin
                            next_s.seq[0] = OP_REG_WRITE | {3'h0, req_addr};
                            next_s.seq[2] = req_wdata;
                            next_s.nbytes = 3'h3;
                        end
                        default: begin
                            // Continuous fetch: wait for ready, then clock out three bytes
                            next_s.wait_at = 3'h0;
                            next_s.nbytes = 3'h3;
                        end
                    endcase
                end
            end
            HS_GAP: begin
                next_s.gap = s.gap + 5'h01;
                if (s.gap == 5'(BYTE_GAP_CLKS - 1)) begin
                    next_s.gap = '0;
                    next_s.st = (s.idx == s.wait_at) ? HS_WAIT : HS_SHIFT;
                    next_s.txb = s.seq[s.idx];
                    next_s.din = s.seq[s.idx][7];
                end
            end
            HS_WAIT: begin
                if (!s.rr_p[1]) begin
                    next_s.st = HS_SHIFT;
                end
            end
            HS_SHIFT: begin
                next_s.div = s.div + 4'h1;
                if (s.div == 4'(SCLK_HALF_CLKS - 1)) begin
                    next_s.div = '0;
                    next_s.sclk = ~s.sclk;
                    if (!s.sclk) begin
                        next_s.rx = {s.rx[22:0], s.dout_p[1]};
                    end else begin
                        next_s.txb = {s.txb[6:0], 1'b0};
                        next_s.din = s.txb[6];
                        next_s.bitn = s.bitn + 3'h1;
                        if (s.bitn == 3'h7) begin
                            next_s.idx = s.idx + 3'h1;
                            next_s.din = 1'b0;
                            if (s.idx + 3'h1 == s.nbytes) begin
                                next_s.st = HS_IDLE;
                                next_s.ready = 1'b1;
                                next_s.rvalid = 1'b1;
                            end else begin
                                next_s.st = HS_GAP;
                            end
                        end
                    end
                end
            end
        endcase
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s <= '{st: HS_IDLE, ready: 1'b1, rr_p: 2'b11, wait_at: 3'h7, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign link.sclk = s.sclk;
    assign link.din = s.din;
    assign link.sync = s.sync_o;
    assign link.reset_pin_n = (s.rpulse == '0);
    assign req_ready = s.ready;
    assign resp_valid = s.rvalid;
    assign resp_data = s.rx;
endmodule : adc_cfg_host
`default_nettype wire

// ==== verification/adc_link_chk.sv ====
/*
 Checker of the serial link between host end and converter end.
 Assumes the host clk and its active low resetn.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_link_chk (
    input wire logic clk,
    input wire logic resetn,
    input wire logic sclk,
    input wire logic din,
    input wire logic result_ready_n,
    input wire logic reset_pin_n
);
    // =========================================
    // Helpers: length of a low stretch, bits seen
    logic [4:0] low_cnt;
    logic [2:0] bit_cnt;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            low_cnt <= 5'h1F;
            bit_cnt <= 3'h0;
        end else begin
            low_cnt <= sclk ? 5'h00 : low_cnt + {4'h0, low_cnt != 5'h1F}; // Saturates
            bit_cnt <= bit_cnt + {2'h0, sclk && low_cnt != 5'h00};
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // =========================================
    // Properties
    AST_RST_PULSE: assert property ($fell(reset_pin_n) |-> !reset_pin_n [*4] ##1 reset_pin_n)
        else $error("reset pin pulse length wrong");
    AST_RST_QUIET: assert property (!reset_pin_n |-> !sclk)
        else $error("serial clock runs during reset pin");
    AST_RDY_PIN: assert property ($fell(reset_pin_n) |-> ##[1:6] result_ready_n)
        else $error("ready not released by reset pin");
    AST_DIN_LOW: assert property ($changed(din) |-> !sclk)
        else $error("data changed while serial clock high");
    AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
        else $error("serial clock high phase wrong");
    AST_SCLK_LOW: assert property ($fell(sclk) |-> !sclk [*8])
        else $error("serial clock low phase short");
    AST_BIT_LOW: assert property (sclk && low_cnt != 5'h00 && bit_cnt != 3'h0 |-> low_cnt == 5'h08)
        else $error("gap inside a byte");
    AST_GAP: assert property (sclk && low_cnt > 5'h08 |-> low_cnt >= 5'h18)
        else $error("byte gap under 24 clocks");
endmodule : adc_link_chk
`default_nettype wire

// ==== verification/adc_config_register_bank_tb_top.sv ====
/*
 Bench joining host end and converter end over the link.
 Assumes a conversion period longer than one result frame.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_config_register_bank_tb_top;
    import adc_cfg_pkg::*;
    // Identity 8'hA0 follows the arbitrary IDENTITY value below
    localparam logic [7:0] DEF [0:10] = '{8'hA0, 8'h52, 8'h08, 8'h32, 8'h03, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h40};
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic req_valid = 1'b0;
    host_op_t req_op = HOP_STOP_CONT;
    logic [4:0] req_addr = 5'h00;
    logic [7:0] req_wdata = 8'h00;
    logic sync_level = 1'b1;
    logic reset_req = 1'b0;
    logic [23:0] sample_in = 24'h000000;
    logic req_ready, resp_valid, sync_mode, power_high, phase_min, amp_chopping_enable, continuous;
    logic [2:0] rate_select, input_selector, gain_amplifier;
    logic [1:0] filter_chain_select;
    logic [15:0] highpass_corner;
    logic [23:0] offset_correction, fullscale_correction, resp_data;
    logic [7:0] regs [0:10];
    logic [25:0] exp_q [$];
    logic [25:0] e;
    logic [31:0] seed = 32'h00000057;
    int error_cnt = 0;
    int cmp_count = 0;
    always #5 clk = ~clk;
    adc_link_if link ();
    adc_cfg_device #(.PERIOD_CLKS(600), .IDENTITY(4'hA)) adc_cfg_device_i (.clk(clk),
        .resetn(resetn), .link(link), .sample_in(sample_in), .sync_mode(sync_mode),
        .power_high(power_high), .rate_select(rate_select), .phase_min(phase_min),
        .filter_chain_select(filter_chain_select), .input_selector(input_selector),
        .amp_chopping_enable(amp_chopping_enable), .gain_amplifier(gain_amplifier),
        .highpass_corner(highpass_corner), .offset_correction(offset_correction),
        .fullscale_correction(fullscale_correction), .continuous(continuous));
    adc_cfg_host adc_cfg_host_i (.clk(clk), .resetn(resetn), .link(link), .req_valid(req_valid),
        .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
        .resp_valid(resp_valid), .resp_data(resp_data), .sync_level(sync_level),
        .reset_req(reset_req));
    adc_link_chk adc_link_chk_i (.clk(clk), .resetn(resetn), .sclk(link.sclk), .din(link.din),
        .result_ready_n(link.result_ready_n), .reset_pin_n(link.reset_pin_n));
    // =========================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic complete_run();
        $display("mismatches %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run
    // Bounded wait for the host to be free; a hang ends the run
    task automatic idle();
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 60000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 60000) begin
            error_cnt++;
            complete_run();
        end
    endtask : idle
    // Kind k: 0 no compare, 1 low byte, 2 full word
    task automatic req(input host_op_t op, input logic [4:0] a, input logic [7:0] d,
        input logic [1:0] k, input logic [23:0] x);
        idle();
        exp_q.push_back({k, x});
        req_valid = 1'b1;
        req_op = op;
        req_addr = a;
        req_wdata = d;
        @(negedge clk);
        req_valid = 1'b0;
    endtask : req
    task automatic rd_all();
        for (int i = 0; i <= 10; i++) req(HOP_REG_READ, 5'(i), 8'h00, 2'd1, {16'h0, regs[i]});
        req(HOP_REG_READ, 5'h1F, 8'h00, 2'd1, 24'h000000);
        idle();
    endtask : rd_all
    // Result watcher takes the oldest note per response
    always @(negedge clk) begin
        if (resp_valid === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            if (e[25]) chk(resp_data, e[23:0]);
            else if (e[24]) chk({16'h0, resp_data[7:0]}, e[23:0]);
        end
    end
    // =========================================
    // Main sequence
    initial begin
        seed = xs(seed);
        sample_in = seed[23:0];
        regs = DEF;
        repeat (5) @(negedge clk);
        resetn = 1'b1;
        chk(24'(continuous), 24'h000001);
        req(HOP_STOP_CONT, 5'h00, 8'h00, 2'd0, 24'h0);
        rd_all();
        chk(24'(continuous), 24'h000000);
        for (int i = 0; i <= 10; i++) begin
            seed = xs(seed);
            if (i == 1) seed[5:3] = RATE_FASTEST; // Slow rates would stretch settling
            if (i == 0) seed[7:0] = 8'h00;
            req(HOP_REG_WRITE, 5'(i), seed[7:0], 2'd0, 24'h0);
            if (i > 0) regs[i] = (i == 2) ? (seed[7:0] & INPUT_GAIN_WMASK) : seed[7:0];
        end
        idle();
        chk(24'({sync_mode, power_high, rate_select, phase_min, filter_chain_select}), 24'(regs[1]));
        chk(24'({input_selector, amp_chopping_enable, gain_amplifier}), 24'(regs[2]));
        chk(24'(highpass_corner), {8'h00, regs[4], regs[3]});
        chk(offset_correction, {regs[7], regs[6], regs[5]});
        chk(fullscale_correction, {regs[10], regs[9], regs[8]});
        rd_all();
        req(HOP_CONT_READ, 5'h00, 8'h00, 2'd0, 24'h0);
        sync_level = 1'b0; // Halt and realign conversions
        repeat (20) @(negedge clk);
        sync_level = 1'b1;
        req(HOP_CONT_FETCH, 5'h00, 8'h00, 2'd2, sample_in);
        req(HOP_STOP_CONT, 5'h00, 8'h00, 2'd0, 24'h0);
        req(HOP_READ_DATA, 5'h00, 8'h00, 2'd2, sample_in);
        idle();
        reset_req = 1'b1;
        @(negedge clk);
        reset_req = 1'b0;
        repeat (12) @(negedge clk);
        chk(24'(continuous), 24'h000001);
        chk(fullscale_correction, 24'h400000);
        regs = DEF;
        req(HOP_STOP_CONT, 5'h00, 8'h00, 2'd0, 24'h0);
        rd_all();
        complete_run();
    end
endmodule : adc_config_register_bank_tb_top
`default_nettype wire
